/* File: rtl/acc_regs.svh */
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
// Register byte addresses
`define ACC_ADDR_CTRL     8'h00
`define ACC_ADDR_STATUS   8'h04
`define ACC_ADDR_ETIME    8'h08
`define ACC_ADDR_ID       8'h0C
// Control register fields
`define ACC_CTRL_PRELOAD  0
`define ACC_CTRL_ENABLE   1
`define ACC_CTRL_RESET    32'h0000_0000
// Status register fields
`define ACC_ST_READY      0
`define ACC_ST_MOTOR      1
`define ACC_ST_UNLOAD     2
`define ACC_ST_FAN        3
`define ACC_ST_AVAIL      4
`define ACC_ST_STANDBY    5
`define ACC_ST_LOADED     6
// Identification, arbitrary value
`define ACC_ID_VALUE      32'h0000_A5C3
// Timing
`define ACC_CLK_HZ        200000000
`define ACC_RELAY_MS      1000
`define ACC_UNLOAD_MS     500
`define ACC_TICK_CYC      (`ACC_CLK_HZ)
`define ACC_RELAY_CYC     ((`ACC_CLK_HZ / 1000) * `ACC_RELAY_MS)
`define ACC_UNLOAD_CYC    ((`ACC_CLK_HZ / 1000) * `ACC_UNLOAD_MS)
`endif

/* File: rtl/acc_pkg.sv */
package acc_pkg;
  typedef enum logic [2:0] {
    ACC_OFF     = 3'b000,
    ACC_UNLOAD  = 3'b001,
    ACC_RELAY   = 3'b010,
    ACC_RUNNING = 3'b011
  } acc_motor_t;
  typedef enum logic [1:0] {
    ACC_M_IDLE    = 2'b00,
    ACC_M_RUN     = 2'b01,
    ACC_M_STANDBY = 2'b10
  } acc_mode_t;
endpackage

/* File: rtl/acc_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_divider #(
  parameter int unsigned LIMIT = 200000000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  // Output
  output logic      tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        tick_next;

  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = 32'h0000_0000;
    end else if (cnt_reg == LIMIT - 1) begin
      cnt_next  = 32'h0000_0000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 32'h0000_0000;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/acc_ctrl.sv */
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module acc_ctrl
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Supply, wall air and thermostat
  input  wire logic        mains_ok,
  input  wire logic        wall_air_present,
  input  wire logic        wall_air_ge_26,
  input  wire logic        overtemp_thermostat,
  input  wire logic        power_up_self_check,
  // Accumulator pressure comparators
  input  wire logic        acc_ge_13,
  input  wire logic        acc_ge_22p5,
  input  wire logic        acc_ge_27,
  // Actuators and status
  output logic             unload_solenoid,
  output logic             motor_relay,
  output logic             fans_on,
  output logic             compressor_ready,
  output logic             standby_mode
);
  acc_motor_t  mst_reg,   mst_next;
  acc_mode_t   mode_reg,  mode_next;
  logic [31:0] tmr_reg,   tmr_next;
  logic        vent_reg,  vent_next;
  logic        ready_reg, ready_next;
  logic        want_reg,  want_next;
  logic [31:0] etime_reg, etime_next;
  logic [31:0] ctrl_reg,  ctrl_next;
  logic        loaded_reg, loaded_next;
  logic [31:0] rdata_next;
  logic        ack_next;
  logic        sol_next, relay_next, fan_next;
  logic        avail, wall_ok, sec_tick, motor_on;
  logic        p13, p22, p27;
  logic        wr;

  // Pressure comparators already resolve the at-or-above trip condition
  assign p13 = acc_ge_13;
  assign p22 = acc_ge_22p5;
  assign p27 = acc_ge_27;

  assign wall_ok  = wall_air_present && wall_air_ge_26;
  assign avail    = mains_ok && !overtemp_thermostat && !wall_ok;
  assign motor_on = (mst_reg == ACC_RELAY) || (mst_reg == ACC_RUNNING);
  // Writes land on the edge where the master sees ack, never earlier
  assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  acc_divider #(
    .LIMIT (`ACC_TICK_CYC)
  ) u_sec (
    .clk  (clk),
    .rst  (rst),
    .run  (motor_on),
    .tick (sec_tick)
  );

  // Operating mode and demand for the motor
  always_comb begin
    mode_next  = mode_reg;
    want_next  = want_reg;
    vent_next  = vent_reg;
    ready_next = ready_reg;
    if (!mains_ok || overtemp_thermostat || !ctrl_reg[`ACC_CTRL_ENABLE]) begin
      mode_next = ACC_M_IDLE;
      want_next = 1'b0;
      vent_next = 1'b0;
    end else if (mode_reg == ACC_M_IDLE) begin
      if (power_up_self_check) begin
        mode_next = wall_ok ? ACC_M_STANDBY : ACC_M_RUN;
        want_next = 1'b1;
      end
    end else begin
      if (wall_ok) begin
        mode_next = ACC_M_STANDBY;
      end else if (avail) begin
        mode_next = ACC_M_RUN;
      end
      if (mode_reg == ACC_M_STANDBY) begin
        vent_next = 1'b0;
        if (p27) begin
          want_next = 1'b0;
        end else if (!p22) begin
          want_next = 1'b1;
        end
      end else begin
        want_next = 1'b1;
        if (p27) begin
          vent_next = 1'b1;
        end else if (!p22) begin
          vent_next = 1'b0;
        end
      end
      // Otherwise the previous demand (standby) or vent state (run) stands
      if (p13 && motor_on) begin
        ready_next = 1'b1;
      end
    end
    if (mode_next == ACC_M_IDLE) begin
      ready_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg  <= ACC_M_IDLE;
      want_reg  <= 1'b0;
      vent_reg  <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      mode_reg  <= mode_next;
      want_reg  <= want_next;
      vent_reg  <= vent_next;
      ready_reg <= ready_next;
    end
  end

  // Motor start-up sequencer
  always_comb begin
    mst_next = mst_reg;
    tmr_next = tmr_reg;
    case (mst_reg)
      ACC_OFF: begin
        tmr_next = 32'h0000_0000;
        if (want_reg) begin
          mst_next = ACC_UNLOAD;
        end
      end
      ACC_UNLOAD: begin
        tmr_next = tmr_reg + 32'h0000_0001;
        if (tmr_reg == `ACC_RELAY_CYC - 1) begin
          mst_next = ACC_RELAY;
          tmr_next = 32'h0000_0000;
        end
      end
      ACC_RELAY: begin
        tmr_next = tmr_reg + 32'h0000_0001;
        if (tmr_reg == `ACC_UNLOAD_CYC - 1) begin
          mst_next = ACC_RUNNING;
          tmr_next = 32'h0000_0000;
        end
      end
      ACC_RUNNING: begin
        tmr_next = 32'h0000_0000;
      end
      default: begin
        mst_next = ACC_OFF;
        tmr_next = 32'h0000_0000;
      end
    endcase
    if (!want_reg) begin
      mst_next = ACC_OFF;
      tmr_next = 32'h0000_0000;
    end
  end

  always_comb begin
    sol_next   = (mst_next == ACC_UNLOAD) || (mst_next == ACC_RELAY)
               || ((mst_next == ACC_RUNNING) && vent_next);
    relay_next = (mst_next == ACC_RELAY) || (mst_next == ACC_RUNNING);
    fan_next   = (mst_next != ACC_OFF);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mst_reg          <= ACC_OFF;
      tmr_reg          <= 32'h0000_0000;
      unload_solenoid  <= 1'b0;
      motor_relay      <= 1'b0;
      fans_on          <= 1'b0;
      compressor_ready <= 1'b0;
      standby_mode     <= 1'b0;
    end else begin
      mst_reg          <= mst_next;
      tmr_reg          <= tmr_next;
      unload_solenoid  <= sol_next;
      motor_relay      <= relay_next;
      fans_on          <= fan_next;
      compressor_ready <= ready_next;
      standby_mode     <= (mode_next == ACC_M_STANDBY);
    end
  end

  // Host register access; counting waits for the preload
  always_comb begin
    etime_next  = etime_reg;
    ctrl_next   = ctrl_reg;
    loaded_next = loaded_reg;
    if (wr && wb_adr_i == `ACC_ADDR_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          ctrl_next[8*i +: 8] = wb_dat_i[8*i +: 8];
        end
      end
      if (wb_sel_i[0] && wb_dat_i[`ACC_CTRL_PRELOAD]) begin
        loaded_next = 1'b1;
      end
    end
    if (wr && wb_adr_i == `ACC_ADDR_ETIME) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          etime_next[8*i +: 8] = wb_dat_i[8*i +: 8];
        end
      end
      loaded_next = 1'b1;
    end else if (sec_tick && loaded_reg) begin
      etime_next = etime_reg + 32'h0000_0001;
    end
  end

  always_comb begin
    ack_next   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    rdata_next = 32'h0000_0000;
    case (wb_adr_i)
      `ACC_ADDR_CTRL:   rdata_next = ctrl_reg;
      `ACC_ADDR_STATUS: rdata_next = {25'h0, loaded_reg, standby_mode, avail,
                                      fans_on, unload_solenoid, motor_relay, compressor_ready};
      `ACC_ADDR_ETIME:  rdata_next = etime_reg;
      `ACC_ADDR_ID:     rdata_next = `ACC_ID_VALUE;
      default:          rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      etime_reg  <= 32'h0000_0000;
      ctrl_reg   <= `ACC_CTRL_RESET;
      loaded_reg <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end else begin
      etime_reg  <= etime_next;
      ctrl_reg   <= ctrl_next;
      loaded_reg <= loaded_next;
      wb_ack_o   <= ack_next;
      wb_dat_o   <= rdata_next;
    end
  end
endmodule
`default_nettype wire

/* File: verification/acc_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_sva (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Plant inputs
  input wire logic mains_ok,
  input wire logic overtemp_thermostat,
  input wire logic wall_air_present,
  input wire logic wall_air_ge_26,
  input wire logic acc_ge_13,
  input wire logic acc_ge_27,
  // Actuators and status
  input wire logic unload_solenoid,
  input wire logic motor_relay,
  input wire logic fans_on,
  input wire logic compressor_ready,
  input wire logic standby_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !fans_on && !unload_solenoid && !motor_relay)
    else $error("active in reset");
  a_mains_off: assert property (!mains_ok |-> ##[1:4] !fans_on && !motor_relay) else $error("runs on low mains");
  a_heat_off: assert property (overtemp_thermostat |-> ##[1:4] !fans_on && !motor_relay)
    else $error("runs when hot");
  a_fans_cover: assert property (unload_solenoid || motor_relay |-> fans_on) else $error("fans off");
  a_start_unload: assert property ($rose(fans_on) |-> unload_solenoid && !motor_relay) else $error("bad start");
  a_relay_late: assert property ($rose(fans_on) |=> !motor_relay [*8]) else $error("relay early");
  a_ready_trip: assert property ($rose(compressor_ready) |-> $past(acc_ge_13)) else $error("ready early");
  a_standby_wall: assert property ($rose(standby_mode) |-> $past(wall_air_present && wall_air_ge_26))
    else $error("bad standby");
  a_standby_stop: assert property (standby_mode && acc_ge_27 |-> ##[1:4] !fans_on) else $error("no stop at top trip");
  c_start: cover property ($rose(unload_solenoid));
  c_standby: cover property ($rose(standby_mode));
  c_bus: cover property (wb_ack_o);
endmodule
`default_nettype wire

/* File: verification/acc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_host (
  // Clock
  input wire logic clk,
  // Bus toward the compressor logic
  output logic        wb_cyc_i,
  output logic        wb_stb_i,
  output logic        wb_we_i,
  output logic [7:0]  wb_adr_i,
  output logic [3:0]  wb_sel_i,
  output logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
  end
  // One classic cycle; caller enters right after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Released data must not look like a held value
    wb_dat_i <= ~d;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: verification/acc_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module acc_ctrl_bench;
  logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, d;
  logic        mains_ok, wall_air_present, wall_air_ge_26, overtemp_thermostat, power_up_self_check;
  logic        acc_ge_13, acc_ge_22p5, acc_ge_27;
  logic        unload_solenoid, motor_relay, fans_on, compressor_ready, standby_mode;
  int          err_total, n_tests, cyc_cnt;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  acc_ctrl u_acc_ctrl (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .mains_ok, .wall_air_present, .wall_air_ge_26, .overtemp_thermostat, .power_up_self_check,
    .acc_ge_13, .acc_ge_22p5, .acc_ge_27, .unload_solenoid, .motor_relay, .fans_on, .compressor_ready,
    .standby_mode);
  acc_host u_acc_host (.clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Actuator latency is a few cycles, so eight is a safe settle time
  task automatic outs(input logic [2:0] e);
    repeat (8) @(posedge clk);
    chk("relay_sol_fans", 32'(e), 32'({motor_relay, unload_solenoid, fans_on}));
  endtask
  task automatic t_regs;
    u_acc_host.xfer(1'b0, `ACC_ADDR_ID, 32'h0, d);
    chk("id", `ACC_ID_VALUE, d);
    u_acc_host.xfer(1'b0, `ACC_ADDR_CTRL, 32'h0, d);
    chk("ctrl", `ACC_CTRL_RESET, d);
    u_acc_host.xfer(1'b1, 8'h10, 32'hFFFF_FFFF, d);
    u_acc_host.xfer(1'b0, 8'h10, 32'h0, d);
    chk("unmapped", 32'h0, d);
  endtask
  task automatic t_preload;
    u_acc_host.xfer(1'b1, `ACC_ADDR_ETIME, 32'h0000_1234, d);
    u_acc_host.xfer(1'b0, `ACC_ADDR_STATUS, 32'h0, d);
    chk("status_loaded", 32'h0000_0040, d);
  endtask
  task automatic t_start;
    mains_ok <= 1'b1;
    power_up_self_check <= 1'b1;
    u_acc_host.xfer(1'b1, `ACC_ADDR_CTRL, 32'h0000_0003, d);
    outs(3'b011);
    u_acc_host.xfer(1'b0, `ACC_ADDR_STATUS, 32'h0, d);
    chk("status_start", 32'h0000_005C, d);
    repeat (1000) @(posedge clk);
    chk("relay_held", 32'h0, 32'(motor_relay));
    u_acc_host.xfer(1'b0, `ACC_ADDR_ETIME, 32'h0, d);
    chk("etime_idle", 32'h0000_1234, d);
  endtask
  task automatic t_trips;
    overtemp_thermostat <= 1'b1;
    outs(3'b000);
    overtemp_thermostat <= 1'b0;
    outs(3'b011);
    mains_ok <= 1'b0;
    outs(3'b000);
    u_acc_host.xfer(1'b0, `ACC_ADDR_STATUS, 32'h0, d);
    chk("avail_low_mains", 32'h0, d & 32'h0000_0010);
    mains_ok <= 1'b1;
  endtask
  task automatic t_wall;
    wall_air_present <= 1'b1;
    wall_air_ge_26 <= 1'b1;
    outs(3'b011);
    chk("standby", 32'h1, 32'(standby_mode));
    u_acc_host.xfer(1'b0, `ACC_ADDR_STATUS, 32'h0, d);
    chk("avail_wall", 32'h0, d & 32'h0000_0010);
    {acc_ge_13, acc_ge_22p5, acc_ge_27} <= 3'b111;
    outs(3'b000);
    acc_ge_27 <= 1'b0;
    outs(3'b000);
    acc_ge_22p5 <= 1'b0;
    outs(3'b011);
    acc_ge_22p5 <= 1'b1;
    outs(3'b011);
  endtask
  // Mid-run reset drops the enable and the preload, so software must redo both
  task automatic t_reset;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset_outs", 32'h0, 32'({motor_relay, unload_solenoid, fans_on, standby_mode}));
    rst <= 1'b0;
    @(posedge clk);
    u_acc_host.xfer(1'b0, `ACC_ADDR_STATUS, 32'h0, d);
    chk("status_reset", 32'h0, d);
    u_acc_host.xfer(1'b0, `ACC_ADDR_CTRL, 32'h0, d);
    chk("ctrl_reset", `ACC_CTRL_RESET, d);
  endtask
  initial begin
    {rst, mains_ok, wall_air_present, wall_air_ge_26, overtemp_thermostat} = 5'b10000;
    {power_up_self_check, acc_ge_13, acc_ge_22p5, acc_ge_27} = 4'b0000;
    {err_total, n_tests} = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_preload();
    t_start();
    t_trips();
    t_wall();
    t_reset();
    report_and_stop();
  end
  initial begin
    cyc_cnt = 0;
    forever begin
      @(posedge clk);
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
        err_total++;
        report_and_stop();
      end
    end
  end
endmodule
bind acc_ctrl acc_ctrl_sva u_acc_ctrl_sva (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mains_ok,
  .overtemp_thermostat, .wall_air_present, .wall_air_ge_26, .acc_ge_13, .acc_ge_27, .unload_solenoid, .motor_relay,
  .fans_on, .compressor_ready, .standby_mode);
`default_nettype wire
